// ---- cpl_pkg.sv ----
package cpl_pkg;
    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int PD_TMO_NS = 1000000;
    localparam int PD_TMO_CYC = PD_TMO_NS / CLK_PERIOD_NS;
    localparam int ATTEMPT_NS = 500000;
    localparam int ATTEMPT_CYC = ATTEMPT_NS / CLK_PERIOD_NS;
    localparam int TMR_W = 20;
    localparam logic [2:0] DS_BASE_CNT = 3'h2;

    // ---------------------------------------------------------------
    // Register addresses
    // ---------------------------------------------------------------
    localparam logic [7:0] RA_CTRL = 8'h00;
    localparam logic [7:0] RA_STAT = 8'h01;
    localparam logic [7:0] RA_XCTL = 8'h12;
    localparam logic [7:0] RA_INT = 8'h1A;
    localparam logic [7:0] RA_AUX = 8'h1C;
    localparam logic [7:0] RA_E1_MAN = 8'h53;
    localparam logic [7:0] RA_E1_DSH = 8'h54;
    localparam logic [7:0] RA_E1_PD = 8'h57;
    localparam logic [7:0] RA_E2_EEE = 8'h91;

    // ---------------------------------------------------------------
    // Reset values and write masks
    // ---------------------------------------------------------------
    localparam logic [15:0] RST_CTRL = 16'h1140;
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [15:0] MSK_CTRL = 16'h3140;
    localparam logic [15:0] MSK_XCTL = 16'h00B0;
    localparam logic [15:0] MSK_MAN = 16'h000C;
    localparam logic [15:0] MSK_DSH = 16'h001C;
    localparam logic [15:0] MSK_PD = 16'h0400;
    localparam logic [15:0] MSK_EEE = 16'h8020;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int B_SPD_MSB = 6;
    localparam int B_SPD_LSB = 13;
    localparam int B_AN_EN = 12;
    localparam int B_DUPLEX = 8;
    localparam int B_LINK = 2;
    localparam int B_NOX_FRC = 7;
    localparam int B_NOX = 5;
    localparam int B_NOPOL = 4;
    localparam int B_X_ST = 13;
    localparam int B_CD_ST = 12;
    localparam int B_POL_ST = 8;
    localparam int B_MAN_X = 2;
    localparam int B_DS_EN = 4;
    localparam int B_DS_CNT = 2;
    localparam int B_DS_ST = 1;
    localparam int B_PD_EN = 10;
    localparam int B_PD_ST = 8;
    localparam int B_PD_INT = 9;
    localparam int B_FRC_GIG = 5;
    localparam int B_TX10E = 15;

    // ---------------------------------------------------------------
    // Encodings and types
    // ---------------------------------------------------------------
    localparam logic [1:0] SPD_10 = 2'h0;
    localparam logic [1:0] SPD_100 = 2'h1;
    localparam logic [1:0] SPD_1000 = 2'h2;
    localparam logic [1:0] PD_SEARCH = 2'h0;
    localparam logic [1:0] PD_FOUND = 2'h1;
    localparam logic [1:0] PD_NONE = 2'h2;

    typedef enum logic [3:0] {
        ST_DETECT = 4'b0001,
        ST_NEG = 4'b0010,
        ST_LINK = 4'b0100,
        ST_FORCE = 4'b1000
    } cpl_state_t;

    typedef struct packed {
        logic [5:0] lp_abil;
        logic lp_master;
        logic nway;
        logic [1:0] pd_speed;
        logic loopback;
        logic link_ok;
        logic [1:0] pair_map;
        logic [3:0] pol_inv;
    } cpl_line_t;
endpackage : cpl_pkg

// ---- cpl_line_sync.sv ----
`timescale 1ns/1ps
module cpl_line_sync import cpl_pkg::*; #(
    parameter int W = 1
) (
    input wire logic core_clk_in, // Core clock
    input wire logic reset_in, // Sync reset, active high
    input wire logic ce_in, // Clock enable
    input wire logic [W-1:0] d_in, // Raw pin levels
    output logic [W-1:0] q_out // Filtered levels
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] q_reg;
    logic [W-1:0] q_next;

    // Accept a change once stages two and three agree
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            assign q_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i]
                                                        : q_reg[i];
        end
    endgenerate

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            q_reg <= '0;
        end else if (ce_in) begin
            s1_reg <= d_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            q_reg <= q_next;
        end
    end

    assign q_out = q_reg;
endmodule : cpl_line_sync

// ---- cpl_port_ctrl.sv ----
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module cpl_port_ctrl import cpl_pkg::*; #(
    parameter int PD_TMO_CYCLES = PD_TMO_CYC,
    parameter int ATTEMPT_CYCLES = ATTEMPT_CYC
) (
    input wire logic core_clk_in, // Core clock
    input wire logic reset_in, // Sync reset, active high
    input wire logic ce_in, // Clock enable
    input wire logic [7:0] addr_in, // Register address
    input wire logic [15:0] wdata_in, // Write data
    input wire logic wr_en_in, // Write strobe
    input wire logic rd_en_in, // Read strobe
    output logic [15:0] rdata_out, // Read data, next cycle
    input wire cpl_line_t line_in, // Line-side pin levels
    input wire logic lpi_req_in, // MAC asks for low-power idle
    output logic [1:0] speed_out, // Operating speed
    output logic duplex_out, // Full duplex
    output logic master_out, // Gigabit master role
    output logic link_up_out, // Link established
    output logic adv_gig_out, // Gigabit advertised
    output logic pd_flp_tx_out, // Detection pulses sent
    output logic pd_irq_out, // Detection flag pending
    output logic mdix_out, // Crossed pair mapping
    output logic cd_swap_out, // C and D pairs swapped
    output logic [3:0] pol_corr_out, // Pair polarity inverts
    output logic lpi_active_out, // Low-power idle active
    output logic tx10e_out, // Reduced amplitude 10 Mb
    output logic gig_test_out // Forced gigabit test mode
);
    localparam logic [TMR_W-1:0] TMO_LAST = TMR_W'(PD_TMO_CYCLES - 1);
    localparam logic [TMR_W-1:0] ATT_LAST = TMR_W'(ATTEMPT_CYCLES - 1);

    // ---------------------------------------------------------------
    // Line input synchroniser
    // ---------------------------------------------------------------
    cpl_line_t ln;
    logic [$bits(cpl_line_t)-1:0] ln_vec;

    cpl_line_sync #(.W($bits(cpl_line_t))) u_sync (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .ce_in(ce_in),
        .d_in(line_in),
        .q_out(ln_vec)
    );
    assign ln = ln_vec;

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    logic [15:0] ctrl_reg, ctrl_next;
    logic [15:0] xctl_reg, xctl_next;
    logic [15:0] man_reg, man_next;
    logic [15:0] dsc_reg, dsc_next;
    logic [15:0] pdc_reg, pdc_next;
    logic [15:0] eee_reg, eee_next;
    logic [15:0] rdata_reg, rdata_next;
    cpl_state_t state_reg, state_next;
    logic [TMR_W-1:0] tmr_reg, tmr_next;
    logic [2:0] fail_reg, fail_next;
    logic ds_reg, ds_next;
    logic det_arm_reg, det_arm_next;
    logic [1:0] pd_st_reg, pd_st_next;
    logic pd_flag_reg, pd_flag_next;
    logic [1:0] spd_reg, spd_next;
    logic dup_reg, dup_next;
    logic ms_reg, ms_next;
    logic link_reg, link_next;
    logic mdix_reg, mdix_next;
    logic cd_reg, cd_next;
    logic [3:0] pol_reg, pol_next;

    logic an_en, pd_en, auto_x, set_ev, int_rd;
    logic [1:0] frc_spd, man_x, res_spd;
    logic res_dup;
    logic [2:0] ds_limit;
    logic [5:0] common;

    assign an_en = ctrl_reg[B_AN_EN];
    assign frc_spd = {ctrl_reg[B_SPD_MSB], ctrl_reg[B_SPD_LSB]};
    assign pd_en = pdc_reg[B_PD_EN];
    assign man_x = man_reg[B_MAN_X +: 2];
    assign ds_limit = DS_BASE_CNT + {1'b0, dsc_reg[B_DS_CNT +: 2]};
    assign int_rd = rd_en_in && (addr_in == RA_INT);
    assign set_ev = ce_in && state_reg == ST_DETECT && an_en
                    && ln.loopback;

    // ---------------------------------------------------------------
    // Register bus
    // ---------------------------------------------------------------
    always_comb begin
        ctrl_next = ctrl_reg;
        xctl_next = xctl_reg;
        man_next = man_reg;
        dsc_next = dsc_reg;
        pdc_next = pdc_reg;
        eee_next = eee_reg;
        rdata_next = 16'h0000;
        if (wr_en_in) begin
            case (addr_in)
                RA_CTRL: ctrl_next = wdata_in & MSK_CTRL;
                RA_XCTL: xctl_next = wdata_in & MSK_XCTL;
                RA_E1_MAN: man_next = wdata_in & MSK_MAN;
                RA_E1_DSH: dsc_next = wdata_in & MSK_DSH;
                RA_E1_PD: pdc_next = wdata_in & MSK_PD;
                RA_E2_EEE: eee_next = wdata_in & MSK_EEE;
                default: ctrl_next = ctrl_reg;
            endcase
        end
        if (rd_en_in) begin
            case (addr_in)
                RA_CTRL: rdata_next = ctrl_reg;
                RA_STAT: rdata_next[B_LINK] = link_reg;
                RA_XCTL: rdata_next = xctl_reg;
                RA_INT: rdata_next[B_PD_INT] = pd_flag_reg;
                RA_AUX: begin
                    rdata_next[B_X_ST] = mdix_reg;
                    rdata_next[B_CD_ST] = cd_reg;
                    rdata_next[B_POL_ST +: 4] = pol_reg;
                end
                RA_E1_MAN: rdata_next = man_reg;
                RA_E1_DSH: begin
                    rdata_next = dsc_reg;
                    rdata_next[B_DS_ST] = ds_reg;
                end
                RA_E1_PD: begin
                    rdata_next = pdc_reg;
                    rdata_next[B_PD_ST +: 2] = pd_st_reg;
                end
                RA_E2_EEE: rdata_next = eee_reg;
                default: rdata_next = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            ctrl_reg <= RST_CTRL;
            xctl_reg <= RST_ZERO;
            man_reg <= RST_ZERO;
            dsc_reg <= RST_ZERO;
            pdc_reg <= RST_ZERO;
            eee_reg <= RST_ZERO;
            rdata_reg <= RST_ZERO;
        end else if (ce_in) begin
            ctrl_reg <= ctrl_next;
            xctl_reg <= xctl_next;
            man_reg <= man_next;
            dsc_reg <= dsc_next;
            pdc_reg <= pdc_next;
            eee_reg <= eee_next;
            rdata_reg <= rdata_next;
        end
    end

    // ---------------------------------------------------------------
    // Ability resolution
    // ---------------------------------------------------------------
    always_comb begin
        common = ln.lp_abil & {ds_reg ? 2'b00 : 2'b11, 4'hF};
        res_spd = SPD_10;
        res_dup = 1'b0;
        if (!ln.nway) begin
            res_spd = ln.pd_speed;
        end else if (common[5] || common[4]) begin
            res_spd = SPD_1000;
            res_dup = common[5];
        end else if (common[3] || common[2]) begin
            res_spd = SPD_100;
            res_dup = common[3];
        end else begin
            res_dup = common[1];
        end
    end

    // ---------------------------------------------------------------
    // Port state machine
    // ---------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        tmr_next = tmr_reg;
        fail_next = fail_reg;
        ds_next = ds_reg;
        det_arm_next = det_arm_reg;
        pd_st_next = pd_st_reg;
        pd_flag_next = pd_flag_reg & ~int_rd;
        spd_next = spd_reg;
        dup_next = dup_reg;
        ms_next = ms_reg;
        if (wr_en_in && addr_in == RA_E1_PD && wdata_in[B_PD_EN]) begin
            det_arm_next = 1'b1;
        end
        case (state_reg)
            ST_DETECT: begin
                if (!an_en) begin
                    state_next = ST_FORCE;
                end else if (ln.loopback) begin
                    pd_st_next = PD_FOUND;
                    pd_flag_next = 1'b1;
                    state_next = ST_NEG;
                    tmr_next = '0;
                end else if (tmr_reg == TMO_LAST) begin
                    pd_st_next = PD_NONE;
                    state_next = ST_NEG;
                    tmr_next = '0;
                end else begin
                    tmr_next = tmr_reg + 1'b1;
                end
            end
            ST_NEG: begin
                if (!an_en) begin
                    state_next = ST_FORCE;
                end else if (det_arm_reg && pd_en) begin
                    state_next = ST_DETECT;
                    det_arm_next = 1'b0;
                    pd_st_next = PD_SEARCH;
                    tmr_next = '0;
                end else if (ln.link_ok) begin
                    state_next = ST_LINK;
                    spd_next = res_spd;
                    dup_next = res_dup;
                    ms_next = ~ln.lp_master;
                    fail_next = '0;
                end else if (tmr_reg == ATT_LAST) begin
                    tmr_next = '0;
                    if (ln.nway && res_spd == SPD_1000) begin
                        fail_next = (fail_reg == 3'h7) ? fail_reg
                                                       : fail_reg + 1'b1;
                        if (dsc_reg[B_DS_EN] && fail_next >= ds_limit) begin
                            ds_next = 1'b1;
                            fail_next = '0;
                        end
                    end
                end else begin
                    tmr_next = tmr_reg + 1'b1;
                end
            end
            ST_LINK: begin
                if (!an_en) begin
                    state_next = ST_FORCE;
                end else if (!ln.link_ok) begin
                    state_next = ST_NEG;
                    det_arm_next = 1'b1;
                    ds_next = 1'b0;
                    fail_next = '0;
                    tmr_next = '0;
                end
            end
            ST_FORCE: begin
                spd_next = frc_spd;
                dup_next = ctrl_reg[B_DUPLEX];
                ms_next = ~ln.lp_master;
                if (an_en) begin
                    state_next = ST_NEG;
                    det_arm_next = 1'b1;
                    tmr_next = '0;
                end
            end
            default: state_next = ST_NEG;
        endcase
        if (set_ev) begin
            pd_flag_next = 1'b1;
        end
        link_next = (state_next == ST_LINK)
                    || (state_next == ST_FORCE && ln.link_ok
                        && (frc_spd != SPD_1000 || gig_test_out));
    end

    // ---------------------------------------------------------------
    // Crossover and polarity
    // ---------------------------------------------------------------
    always_comb begin
        auto_x = !xctl_reg[B_NOX] && (an_en || (!xctl_reg[B_NOX_FRC]
                 && frc_spd != SPD_1000));
        mdix_next = 1'b0;
        cd_next = 1'b0;
        if (man_x == 2'b11) begin
            mdix_next = 1'b1;
        end else if (man_x == 2'b00 && auto_x) begin
            mdix_next = ln.pair_map[0];
            cd_next = ln.pair_map[1];
        end
        pol_next = xctl_reg[B_NOPOL] ? 4'h0 : ln.pol_inv;
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            state_reg <= ST_NEG;
            tmr_reg <= '0;
            fail_reg <= '0;
            ds_reg <= 1'b0;
            det_arm_reg <= 1'b1;
            pd_st_reg <= PD_SEARCH;
            pd_flag_reg <= 1'b0;
            spd_reg <= SPD_10;
            dup_reg <= 1'b0;
            ms_reg <= 1'b0;
            link_reg <= 1'b0;
            mdix_reg <= 1'b0;
            cd_reg <= 1'b0;
            pol_reg <= 4'h0;
        end else if (ce_in) begin
            state_reg <= state_next;
            tmr_reg <= tmr_next;
            fail_reg <= fail_next;
            ds_reg <= ds_next;
            det_arm_reg <= det_arm_next;
            pd_st_reg <= pd_st_next;
            pd_flag_reg <= pd_flag_next;
            spd_reg <= spd_next;
            dup_reg <= dup_next;
            ms_reg <= ms_next;
            link_reg <= link_next;
            mdix_reg <= mdix_next;
            cd_reg <= cd_next;
            pol_reg <= pol_next;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign rdata_out = rdata_reg;
    assign speed_out = spd_reg;
    assign duplex_out = dup_reg;
    assign master_out = ms_reg;
    assign link_up_out = link_reg;
    assign adv_gig_out = ~ds_reg;
    assign pd_flp_tx_out = (state_reg == ST_DETECT);
    assign pd_irq_out = pd_flag_reg;
    assign mdix_out = mdix_reg;
    assign cd_swap_out = cd_reg;
    assign pol_corr_out = pol_reg;
    assign lpi_active_out = link_reg && lpi_req_in
                            && spd_reg != SPD_10;
    assign tx10e_out = eee_reg[B_TX10E];
    assign gig_test_out = eee_reg[B_FRC_GIG] && !an_en
                          && frc_spd == SPD_1000;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in);

    sequence seq_link_drop;
        ce_in && state_reg == ST_LINK && an_en && pd_en
        && !ln.link_ok && !wr_en_in;
    endsequence

    sequence seq_retry;
        state_reg == ST_NEG ##1 state_reg == ST_DETECT;
    endsequence

    chk_force_speed: assert property (
        ce_in && state_reg == ST_FORCE && !an_en
        |=> speed_out == $past(frc_spd))
        else $error("Forced speed not applied");
    chk_det_search: assert property (
        state_reg == ST_DETECT |-> pd_st_reg == PD_SEARCH && pd_flp_tx_out)
        else $error("Detection search status wrong");
    chk_det_found: assert property (
        set_ev |=> pd_st_reg == PD_FOUND && pd_flag_reg
        && state_reg == ST_NEG)
        else $error("Loopback not reported");
    chk_flag_clear: assert property (
        ce_in && int_rd && !set_ev |=> !pd_flag_reg && !pd_irq_out)
        else $error("Detection flag not cleared by read");
    chk_det_timeout: assert property (
        ce_in && state_reg == ST_DETECT && an_en && !ln.loopback
        && tmr_reg == TMO_LAST |=> pd_st_reg == PD_NONE
        && state_reg == ST_NEG)
        else $error("Detection timeout not handled");
    chk_link_bit: assert property (
        state_reg == ST_LINK |-> link_up_out)
        else $error("Link status missing");
    chk_link_retry: assert property (
        seq_link_drop ##1 ce_in |-> seq_retry)
        else $error("Detection not restarted after link loss");
    chk_ds_return: assert property (
        seq_link_drop |=> adv_gig_out)
        else $error("Gigabit not advertised again");
    chk_mdix_manual: assert property (
        ce_in && man_x[1] |=> mdix_out == $past(man_x[0]))
        else $error("Manual crossover not applied");
    chk_auto_forced: assert property (
        ce_in && !an_en && !xctl_reg[B_NOX_FRC] && !xctl_reg[B_NOX]
        && frc_spd != SPD_1000 && man_x == 2'b00
        |=> mdix_out == $past(ln.pair_map[0]))
        else $error("Forced-mode auto crossover inactive");
    chk_lpi_speed: assert property (
        lpi_active_out |-> link_up_out && speed_out != SPD_10)
        else $error("Low-power idle at wrong speed");
    chk_rd_only_once: assert property (
        ce_in && !rd_en_in |=> rdata_out == 16'h0000)
        else $error("Read data outside its cycle");
endmodule : cpl_port_ctrl

// ---- cpl_lp_model.sv ----
`timescale 1ns/1ps
module cpl_lp_model import cpl_pkg::*; (
    input wire logic flp_in, // Detection pulses from port
    input wire logic loop_en_in, // Partner is a powered device
    input wire logic link_en_in, // Partner able to link
    input wire logic nway_in, // Partner negotiates
    input wire logic [5:0] wiring_in, // Pair map, polarity
    output cpl_line_t line_out // Levels seen by port
);
    always_comb begin
        line_out = '0;
        line_out.lp_abil = 6'h3F;
        line_out.nway = nway_in;
        line_out.pd_speed = SPD_100;
        line_out.pair_map = wiring_in[5:4];
        line_out.pol_inv = wiring_in[3:0];
        line_out.loopback = flp_in & loop_en_in;
        // No link while pulses are still being sent
        line_out.link_ok = link_en_in & ~flp_in;
    end
endmodule : cpl_lp_model

// ---- test_copper_port_link_config.sv ----
`timescale 1ns/1ps
module test_copper_port_link_config import cpl_pkg::*;;
    typedef struct {
        logic [15:0] ctrl, eee;
        logic [1:0] spd;
        logic dpx, gt, t10;
    } cpl_row_t;
    logic core_clk_in = 0, reset_in = 1, wr_en_in = 0, rd_en_in = 0;
    logic [7:0] addr_in = 0;
    logic [15:0] wdata_in = 0, rdata_out, v;
    logic [1:0] speed_out;
    logic [3:0] pol_corr_out;
    logic duplex_out, master_out, link_up_out, adv_gig_out, pd_flp_tx_out;
    logic pd_irq_out, mdix_out, cd_swap_out, lpi_active_out, tx10e_out;
    logic gig_test_out, lpi_req_in = 0, loop_en = 0, link_en = 0;
    logic nway = 1'b1;
    logic [5:0] wiring = 6'h00;
    cpl_line_t line;
    int mismatches = 0, cmp_count = 0, cycles = 0;
    cpl_row_t rows[3] = '{'{16'h0000, 16'h8000, SPD_10, 0, 0, 1},
        '{16'h2100, 16'h0000, SPD_100, 1, 0, 0},
        '{16'h0140, 16'h0020, SPD_1000, 1, 1, 0}};
    always #5 core_clk_in = ~core_clk_in;
    cpl_port_ctrl #(.PD_TMO_CYCLES(20), .ATTEMPT_CYCLES(16)) u_cpl_port_ctrl (
        .core_clk_in(core_clk_in), .reset_in(reset_in), .ce_in(1'b1),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_en_in(wr_en_in),
        .rd_en_in(rd_en_in), .rdata_out(rdata_out), .line_in(line),
        .lpi_req_in(lpi_req_in), .speed_out(speed_out),
        .duplex_out(duplex_out), .master_out(master_out),
        .link_up_out(link_up_out), .adv_gig_out(adv_gig_out),
        .pd_flp_tx_out(pd_flp_tx_out), .pd_irq_out(pd_irq_out),
        .mdix_out(mdix_out), .cd_swap_out(cd_swap_out),
        .pol_corr_out(pol_corr_out), .lpi_active_out(lpi_active_out),
        .tx10e_out(tx10e_out), .gig_test_out(gig_test_out));
    cpl_lp_model u_cpl_lp_model (.flp_in(pd_flp_tx_out),
        .loop_en_in(loop_en), .link_en_in(link_en), .nway_in(nway),
        .wiring_in(wiring), .line_out(line));
    // ----------------------------------------
    // Bus tasks and checks
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_en_in <= 1'b1;
        @(posedge core_clk_in);
        wr_en_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk_in);
        addr_in <= a;
        rd_en_in <= 1'b1;
        @(posedge core_clk_in);
        rd_en_in <= 1'b0;
        #1 v = rdata_out;
    endtask : rd
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask : wt
    task automatic chk(input string n, input logic [15:0] e, s);
        cmp_count++;
        if (s !== e) begin
            $display("mismatch %s expected %h seen %h", n, e, s);
            mismatches++;
        end
    endtask : chk
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up
    always @(posedge core_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            wrap_up();
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge core_clk_in);
        reset_in <= 1'b0;
        rd(RA_CTRL);
        chk("ctrl", RST_CTRL, v);
        rd(RA_XCTL);
        chk("xctl", 16'h0000, v);
        link_en <= 1'b1;
        foreach (rows[i]) begin
            wr(RA_CTRL, rows[i].ctrl);
            wr(RA_E2_EEE, rows[i].eee);
            wt(10);
            chk("speed", rows[i].spd, speed_out);
            chk("duplex", rows[i].dpx, duplex_out);
            chk("gig test", rows[i].gt, gig_test_out);
            chk("tx10e", rows[i].t10, tx10e_out);
        end
        link_en <= 1'b0;
        wr(RA_E2_EEE, 16'h0000);
        wr(RA_CTRL, RST_CTRL);
        wr(RA_E1_PD, 16'h0400);
        wt(3);
        chk("flp", 1, pd_flp_tx_out);
        rd(RA_E1_PD);
        chk("pd search", 16'h0000, v & 16'h0300);
        wt(30);
        rd(RA_E1_PD);
        chk("pd none", 16'h0200, v & 16'h0300);
        chk("flp off", 0, pd_flp_tx_out);
        loop_en <= 1'b1;
        wr(RA_E1_PD, 16'h0400);
        wt(12);
        rd(RA_E1_PD);
        chk("pd found", 16'h0100, v & 16'h0300);
        chk("irq", 1, pd_irq_out);
        rd(RA_INT);
        chk("int", 16'h0200, v & 16'h0200);
        chk("irq clr", 0, pd_irq_out);
        rd(RA_INT);
        chk("int clr", 16'h0000, v & 16'h0200);
        // Switch powers the cable itself here
        loop_en <= 1'b0;
        link_en <= 1'b1;
        wiring <= 6'h39;
        wt(10);
        chk("link", 1, link_up_out);
        chk("neg speed", SPD_1000, speed_out);
        chk("neg dpx", 1, duplex_out);
        rd(RA_STAT);
        chk("stat", 16'h0004, v & 16'h0004);
        @(posedge core_clk_in) lpi_req_in <= 1'b1;
        wt(1);
        chk("lpi", 1, lpi_active_out);
        @(posedge core_clk_in) lpi_req_in <= 1'b0;
        chk("master", 1, master_out);
        rd(RA_AUX);
        chk("aux", 16'h3900, v);
        chk("pol", 4'h9, pol_corr_out);
        wr(RA_E1_MAN, 16'h0008);
        wt(2);
        chk("mdi", 0, mdix_out);
        wr(RA_E1_MAN, 16'h000C);
        wt(2);
        chk("mdix", 1, mdix_out);
        chk("cd man", 0, cd_swap_out);
        wr(RA_XCTL, 16'h0030);
        wr(RA_E1_MAN, 16'h0000);
        wt(2);
        chk("no auto", 0, mdix_out);
        chk("no pol", 0, pol_corr_out);
        link_en <= 1'b0;
        wt(8);
        chk("link down", 0, link_up_out);
        chk("redetect", 1, pd_flp_tx_out);
        rd(8'h3F);
        chk("unmapped", 16'h0000, v);
        wr(RA_E1_DSH, 16'h0010);
        wt(80);
        chk("gig off", 0, adv_gig_out);
        rd(RA_E1_DSH);
        chk("ds st", 16'h0002, v & 16'h0002);
        link_en <= 1'b1;
        wt(10);
        chk("ds speed", SPD_100, speed_out);
        link_en <= 1'b0;
        wt(8);
        chk("gig again", 1, adv_gig_out);
        nway <= 1'b0;
        link_en <= 1'b1;
        wt(40);
        chk("pd speed", SPD_100, speed_out);
        chk("pd dpx", 0, duplex_out);
        wrap_up();
    end
endmodule : test_copper_port_link_config
